// ### design/sbc_reset_supervisor.v
// supervisor pin logic toward the host controller
`timescale 1ns/1ps
`include "sbc_supervisor_defines.vh"
module sbc_reset_supervisor #(
   parameter SHORT_VARIANT = 0,
   parameter HOLD_STD_CYC = `RST_HOLD_STD_CYC,
   parameter HOLD_SHORT_CYC = `RST_HOLD_SHORT_CYC,
   parameter WATCHDOG_FAULT_OUT_N_TIMEOUT_CYC = 12500000
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // supply monitor and interrupt sources
   input wire vdd_undervoltage,
   input wire [3:0] irq_src,
   // host reset, interrupt, watchdog
   output reg host_reset_out_n,
   output reg interrupt_out_n,
   output reg watchdog_fault_out_n,
   // spi pins
   input wire spi_sclk,
   input wire spi_cs_n,
   input wire spi_mosi,
   output wire spi_miso_o,
   output wire spi_miso_oe,
   // can logic pins
   input wire can_txd_in,
   output reg can_rxd_out,
   input wire can_bus_rx,
   output reg can_bus_tx,
   // mode
   output reg [1:0] op_mode_r
);
   // =====================================================
   // pin synchronisers
   reg [1:0] sclk_q, cs_q, mosi_q, uv_q, txd_q, brx_q;
   reg [3:0] irq_q1, irq_q2;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_q <= 2'h0;
         cs_q <= 2'h3;
         mosi_q <= 2'h0;
         uv_q <= 2'h0;
         txd_q <= 2'h3;
         brx_q <= 2'h3;
         irq_q1 <= 4'h0;
         irq_q2 <= 4'h0;
      end else begin
         sclk_q <= {sclk_q[0], spi_sclk};
         cs_q <= {cs_q[0], spi_cs_n};
         mosi_q <= {mosi_q[0], spi_mosi};
         uv_q <= {uv_q[0], vdd_undervoltage};
         txd_q <= {txd_q[0], can_txd_in};
         brx_q <= {brx_q[0], can_bus_rx};
         irq_q1 <= irq_src;
         irq_q2 <= irq_q1;
      end
   end
   // =====================================================
   // spi command path
   wire [7:0] rx_word;
   wire rx_done;
   wire miso_bit;
   reg [3:0] irq_en_r;
   reg [3:0] irq_pend_r;
   spi_frame_slave #(.BITS(`SPI_BITS)) u_spi (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .sclk_s(sclk_q[1]),
      .cs_n_s(cs_q[1]),
      .mosi_s(mosi_q[1]),
      .tx_word({op_mode_r, ~watchdog_fault_out_n, 1'b0, irq_pend_r}),
      .miso_r(miso_bit),
      .rx_word_r(rx_word),
      .rx_done_r(rx_done)
   );
   assign spi_miso_o = miso_bit;
   assign spi_miso_oe = ~cs_q[1];
   // command decode, shared by all three strobes
   function is_cmd;
      input done;
      input [7:0] word;
      input [1:0] code;
      begin
         is_cmd = done && (word[7:6] == code);
      end
   endfunction
   wire cmd_mode = is_cmd(rx_done, rx_word, `CMD_MODE);
   wire cmd_watchdog_fault_out_n = is_cmd(rx_done, rx_word, `CMD_WATCHDOG_FAULT_OUT_N);
   wire cmd_inten = is_cmd(rx_done, rx_word, `CMD_INTEN);
   // =====================================================
   // watchdog
   localparam [23:0] WD_LAST = WATCHDOG_FAULT_OUT_N_TIMEOUT_CYC - 1;
   reg [23:0] wd_cnt_r;
   wire wd_miss = wd_cnt_r == WD_LAST;
   // =====================================================
   // reset supervisor
   reg [1:0] st_r;
   reg [20:0] hold_r;
   wire [20:0] hold_len = SHORT_VARIANT ? HOLD_SHORT_CYC[20:0] : HOLD_STD_CYC[20:0];
   wire in_run = st_r == `ST_RUN;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= `ST_RESET;
         hold_r <= 21'h0;
         host_reset_out_n <= 1'b0;
         wd_cnt_r <= 24'h0;
         watchdog_fault_out_n <= 1'b1;
      end else begin
         if (in_run && (uv_q[1] || wd_miss)) begin
            st_r <= `ST_RESET;
            hold_r <= 21'h0;
            host_reset_out_n <= 1'b0;
         end else if (!in_run) begin
            if (uv_q[1])
               hold_r <= 21'h0;
            else if (hold_r >= hold_len - 21'h1) begin
               st_r <= `ST_RUN;
               host_reset_out_n <= 1'b1;
            end else
               hold_r <= hold_r + 21'h1;
         end
         if (!in_run || cmd_watchdog_fault_out_n)
            wd_cnt_r <= 24'h0;
         else
            wd_cnt_r <= wd_cnt_r + 24'h1;
         if (in_run && wd_miss)
            watchdog_fault_out_n <= 1'b0;
         else if (cmd_watchdog_fault_out_n)
            watchdog_fault_out_n <= 1'b1;
      end
   end
   // =====================================================
   // modes and interrupts
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         op_mode_r <= `MODE_NORMAL;
         irq_en_r <= 4'h0;
         irq_pend_r <= 4'h0;
         interrupt_out_n <= 1'b1;
      end else begin
         if (!in_run)
            op_mode_r <= `MODE_NORMAL;
         else if (cmd_mode)
            op_mode_r <= rx_word[1:0];
         if (cmd_inten)
            irq_en_r <= rx_word[3:0];
         // set wins over the read-clear
         irq_pend_r <= (cmd_inten ? 4'h0 : irq_pend_r) | (irq_q2 & irq_en_r);
         interrupt_out_n <= ~|irq_pend_r;
      end
   end
   // =====================================================
   // can logic pins
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         can_rxd_out <= 1'b1;
         can_bus_tx <= 1'b1;
      end else begin
         can_rxd_out <= brx_q[1];
         can_bus_tx <= (op_mode_r == `MODE_NORMAL) ? txd_q[1] : 1'b1;
      end
   end
endmodule // sbc_reset_supervisor

// ### design/sbc_supervisor_defines.vh
// constants for the supervisor pin logic
`ifndef SBC_SUPERVISOR_DEFINES_VH
`define SBC_SUPERVISOR_DEFINES_VH
// clock rate in kHz
`define CLK_KHZ 125000
// reset hold times in microseconds
`define RST_HOLD_STD_US 15000
`define RST_HOLD_SHORT_US 3500
// cycles, longest time rounds down
`define RST_HOLD_STD_CYC ((`RST_HOLD_STD_US * `CLK_KHZ) / 1000)
`define RST_HOLD_SHORT_CYC ((`RST_HOLD_SHORT_US * `CLK_KHZ) / 1000)
// operating modes
`define MODE_NORMAL 2'h0
`define MODE_STANDBY 2'h1
`define MODE_STOP 2'h2
`define MODE_SLEEP 2'h3
// spi frame: cmd bits [7:6], mode field [1:0]
`define SPI_BITS 8
`define CMD_MODE 2'h1
`define CMD_WATCHDOG_FAULT_OUT_N 2'h2
`define CMD_INTEN 2'h3
// supervisor states
`define ST_RESET 2'h0
`define ST_RUN 2'h1
`endif

// ### design/spi_frame_slave.v
// spi slave shift engine, sampled in the system clock domain
`timescale 1ns/1ps
`include "sbc_supervisor_defines.vh"
module spi_frame_slave #(
   parameter BITS = `SPI_BITS
) (
   // clock and reset
   input wire clk_sys,
   input wire rst_n,
   // synchronised spi pins
   input wire sclk_s,
   input wire cs_n_s,
   input wire mosi_s,
   // data to return
   input wire [BITS-1:0] tx_word,
   // results
   output reg miso_r,
   output reg [BITS-1:0] rx_word_r,
   output reg rx_done_r
);
   reg sclk_d_r;
   reg [BITS-1:0] sh_r;
   reg [3:0] cnt_r;
   wire rise = sclk_s & ~sclk_d_r;
   wire fall = ~sclk_s & sclk_d_r;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_r <= 1'b0;
         sh_r <= {BITS{1'b0}};
         cnt_r <= 4'h0;
         miso_r <= 1'b0;
         rx_word_r <= {BITS{1'b0}};
         rx_done_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
         rx_done_r <= 1'b0;
         if (cs_n_s) begin
            cnt_r <= 4'h0;
            sh_r <= tx_word;
            miso_r <= tx_word[BITS-1];
         end else if (rise) begin
            sh_r <= {sh_r[BITS-2:0], mosi_s};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == BITS - 1) begin
               rx_word_r <= {sh_r[BITS-2:0], mosi_s};
               rx_done_r <= 1'b1;
               cnt_r <= 4'h0;
            end
         end else if (fall) begin
            miso_r <= sh_r[BITS-1];
         end
      end
   end
endmodule // spi_frame_slave

// ### sim/sbc_reset_supervisor_chk.sv
// assertion checker for the supervisor pins
`timescale 1ns/1ps
module sbc_reset_supervisor_chk #(parameter HOLD_STD_CYC = 50) (
   // watched pins
   input wire clk_sys,
   input wire rst_n,
   input wire vdd_undervoltage,
   input wire host_reset_out_n,
   input wire watchdog_fault_out_n,
   input wire spi_cs_n,
   input wire spi_miso_oe,
   input wire can_bus_rx,
   input wire can_rxd_out,
   input wire can_bus_tx,
   input wire [1:0] op_mode_r
);
   integer lo_cnt;
   integer q_cnt;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lo_cnt <= 0;
         q_cnt <= 0;
      end else begin
         lo_cnt <= host_reset_out_n ? 0 : lo_cnt + 1;
         q_cnt <= vdd_undervoltage ? 0 : q_cnt + 1;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ====
   // properties
   a_hold_time: assert property ($rose(host_reset_out_n) |-> lo_cnt >= HOLD_STD_CYC - 2)
      else $error("reset released early");
   a_uv_reset: assert property ($rose(vdd_undervoltage) |-> ##[1:4] !host_reset_out_n)
      else $error("no reset on undervoltage");
   a_watchdog_fault_out_n_reset: assert property ($fell(watchdog_fault_out_n) |-> ##[0:3] !host_reset_out_n)
      else $error("no reset on watchdog miss");
   a_reset_release: assert property (q_cnt == HOLD_STD_CYC + 8 |-> host_reset_out_n)
      else $error("reset not released");
   a_miso_off: assert property (spi_cs_n [*4] |-> !spi_miso_oe)
      else $error("miso driven while deselected");
   a_mode_reset: assert property (!host_reset_out_n [*3] |-> op_mode_r == 2'h0)
      else $error("mode not normal in reset");
   a_tx_recessive: assert property ((op_mode_r != 2'h0) [*2] |-> can_bus_tx)
      else $error("transmit not recessive");
   a_rxd_follow: assert property ($stable(can_bus_rx) [*4] |-> can_rxd_out == can_bus_rx)
      else $error("receive output wrong");
endmodule // sbc_reset_supervisor_chk
bind sbc_reset_supervisor sbc_reset_supervisor_chk #(.HOLD_STD_CYC(HOLD_STD_CYC)) u_chk (.*);

// ### sim/host_mcu_model.sv
// host controller model: spi master and transmit data
`timescale 1ns/1ps
module host_mcu_model (
   // spi and can pins
   input wire clk_sys,
   output reg spi_sclk,
   output reg spi_cs_n,
   output reg spi_mosi,
   input wire spi_miso,
   output reg can_txd_in
);
   initial begin
      spi_sclk = 0;
      spi_cs_n = 1;
      spi_mosi = 0;
      can_txd_in = 1;
   end
   // ====
   // one byte, msb first, about 3.9 mhz
   task xfer(input [7:0] b, output [7:0] r);
      integer i;
      begin
         @(posedge clk_sys) #1 spi_cs_n = 0;
         for (i = 7; i >= 0; i = i - 1) begin
            spi_mosi = b[i];
            repeat (16) @(posedge clk_sys);
            #1 spi_sclk = 1;
            r[i] = spi_miso;
            repeat (16) @(posedge clk_sys);
            #1 spi_sclk = 0;
         end
         repeat (16) @(posedge clk_sys);
         #1 spi_cs_n = 1;
         spi_mosi = ~spi_mosi;
      end
   endtask
endmodule // host_mcu_model

// ### sim/sbc_reset_supervisor_tb_top.sv
// self-checking bench for the supervisor pins
`timescale 1ns/1ps
module sbc_reset_supervisor_tb_top;
   localparam HOLD = 50;
   localparam WDT = 3000;
   reg clk_sys = 0;
   reg rst_n = 0;
   reg vdd_undervoltage = 0;
   reg [3:0] irq_src = 4'h0;
   reg can_bus_rx = 1;
   wire host_reset_out_n, interrupt_out_n, watchdog_fault_out_n, can_rxd_out, can_bus_tx;
   wire spi_sclk, spi_cs_n, spi_mosi, spi_miso_o, spi_miso_oe, can_txd_in;
   wire [1:0] op_mode_r;
   wire miso_w = spi_miso_oe ? spi_miso_o : 1'bz;
   integer n_errors = 0;
   integer cmp_count = 0;
   integer k;
   integer m;
   reg [7:0] rb;
   always #4 clk_sys = ~clk_sys;
   sbc_reset_supervisor #(.HOLD_STD_CYC(HOLD), .WATCHDOG_FAULT_OUT_N_TIMEOUT_CYC(WDT)) dut (.*);
   host_mcu_model host (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(miso_w), .can_txd_in(can_txd_in));
   // ====
   // helpers
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("compares %0d mismatches %0d", cmp_count, n_errors);
         if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task wait_lvl(input integer sel, input v, input integer n);
      integer i;
      begin
         for (i = 0; i < n && (sel ? watchdog_fault_out_n : host_reset_out_n) !== v; i = i + 1)
            cyc(1);
         if (i == n) begin
            chk(8'h0, 8'h1);
            give_verdict;
         end
      end
   endtask
   // ====
   // scenarios
   task t_hold;
      begin
         cyc(HOLD - 2);
         chk(host_reset_out_n, 0);
         wait_lvl(0, 1, 12);
      end
   endtask
   task t_modes;
      begin
         host.can_txd_in = 0;
         for (m = 1; m <= 4; m = m + 1) begin
            host.xfer(8'h40 | m[1:0], rb);
            host.xfer(8'h80, rb);
            cyc(4);
            chk(rb[7:6], m[1:0]);
            chk(op_mode_r, m[1:0]);
            chk(can_bus_tx, m[1:0] != 2'h0);
            chk(spi_miso_oe, 0);
         end
      end
   endtask
   task t_irq;
      begin
         host.xfer(8'hC1, rb);
         irq_src = 4'h2;
         cyc(8);
         chk(interrupt_out_n, 1);
         irq_src = 4'h1;
         cyc(8);
         chk(interrupt_out_n, 0);
         irq_src = 4'h0;
         host.xfer(8'hC1, rb);
         cyc(8);
         chk(interrupt_out_n, 1);
      end
   endtask
   task t_can;
      begin
         can_bus_rx = 0;
         host.can_txd_in = 1;
         cyc(6);
         chk({can_rxd_out, can_bus_tx}, 2'h1);
         can_bus_rx = 1;
         host.can_txd_in = 0;
         cyc(6);
         chk({can_rxd_out, can_bus_tx}, 2'h2);
      end
   endtask
   task t_uv;
      begin
         vdd_undervoltage = 1;
         cyc(HOLD * 2);
         chk(host_reset_out_n, 0);
         vdd_undervoltage = 0;
         cyc(HOLD - 2);
         chk(host_reset_out_n, 0);
         wait_lvl(0, 1, 12);
      end
   endtask
   task t_watchdog_fault_out_n;
      begin
         host.xfer(8'h80, rb);
         wait_lvl(1, 0, WDT + 20);
         cyc(3);
         chk(host_reset_out_n, 0);
         wait_lvl(0, 1, HOLD + 20);
         host.xfer(8'h80, rb);
         cyc(4);
         chk(watchdog_fault_out_n, 1);
      end
   endtask
   initial begin
      cyc(20);
      rst_n = 1;
      for (k = 0; k < 6; k = k + 1) begin
         case (k)
            0: t_hold;
            1: t_modes;
            2: t_irq;
            3: t_can;
            4: t_uv;
            default: t_watchdog_fault_out_n;
         endcase
         $display("test %0d done", k);
      end
      give_verdict;
   end
endmodule // sbc_reset_supervisor_tb_top
